// >>> common/ext_irq_map.svh
// Constants for the external interrupt pin logic
// Contract
// - An enabled, unmasked request vectors to that input's own entry, except a cascaded input or slave input zero, which takes a type from the bus.
// - Each request input is synchronized internally and is recognized on an edge or a level.
// - With input zero in cascade mode, the input-two pin becomes acknowledge output zero.
// - With input one in cascade mode, the input-three pin becomes acknowledge output one.
// - In cascade mode an acknowledge output is asserted while its paired request needs a type.
// - In slave mode an active slave-select means a type is on the bus, and it is captured.
// - In slave mode the input-three pin drives the slave request output toward the master.
// - Accepting any hardware interrupt clears the interrupt-enable flag; the code keeps it set if intEnableSet arrives in the same cycle.
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH
`define IRQ_COUNT      5
`define IRQ_TYPE_W     8
`define IRQ_VEC_BASE   8'h0c
`define IRQ_ACK_CYCLES 4
`endif

// >>> common/ext_irq_pkg.sv
// Types for the external interrupt pin logic
package ext_irq_pkg;
    typedef enum logic [1:0] {MODE_NORMAL = 2'h0, MODE_CASCADE = 2'h1, MODE_SLAVE = 2'h2} irqMode_t;
    typedef struct packed {
        logic [4:0] mask;      // 1 = masked
        logic [4:0] levelTrig; // 1 = level, 0 = rising edge
        irqMode_t   mode;      // Applies to input zero; input one uses cascOne
        logic       cascOne;   // Input one in cascade mode
    } irqCfg_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
    } irqVec_t;
endpackage

// >>> verification/irq_peer.sv
// Far-side peripheral model: holds requests and offers types
`timescale 1ns/10ps
module irq_peer
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [4:0] req,
    input  wire logic [7:0] typeVal,
    input  wire logic       show,
    input  wire logic       takeAck,
    output logic      [4:0] irqPin,
    output logic      [7:0] busType
);
    logic [7:0] junk = 8'h00;
    // Requests stay up until the core takes one, lowest index first
    always @(posedge clk_sys)
    begin
        junk <= junk + 8'h5b;
        if (reset)
            irqPin <= 5'h00;
        else
            irqPin <= (takeAck ? irqPin & (irqPin - 5'h01) : irqPin) | req;
    end
    // Released bus shows a moving pattern so a stale type cannot match
    assign busType = show ? typeVal : junk;
endmodule

// >>> verification/tb.sv
// Self-checking bench for the external interrupt pin logic
`timescale 1ns/10ps
module tb;
    import ext_irq_pkg::*;
    logic       clk_sys = 1'b0, reset = 1'b1, vPrev = 1'b0;
    logic       intEnableSet = 1'b0, slaveSelect = 1'b0, slaveReqIn = 1'b0, takeAck = 1'b0;
    logic       intEnable, ackZero, ackOne, slaveReqOut, pinTwoOut, pinThreeOut;
    logic [4:0] req = 5'h00, irqPin;
    logic [7:0] typeVal = 8'h00, busType;
    logic [7:0] expQ[$];
    irqCfg_t    cfg = '0;
    irqVec_t    vecOut;
    int         errors = 0, checks_done = 0, cycles = 0, seed = 32'he498ad0f;
    always #12.5 clk_sys = ~clk_sys;
    ext_irq_pins dut (.clk_sys(clk_sys), .reset(reset), .cfg(cfg), .intEnableSet(intEnableSet),
        .irqPin(irqPin), .slaveSelect(slaveSelect), .busType(busType), .slaveReqIn(slaveReqIn),
        .takeAck(takeAck), .vecOut(vecOut), .intEnable(intEnable), .cascade_ack_zero(ackZero),
        .cascade_ack_one(ackOne), .slaveReqOut(slaveReqOut), .pinTwoIsOutput(pinTwoOut),
        .pinThreeIsOutput(pinThreeOut));
    irq_peer peer (.clk_sys(clk_sys), .reset(reset), .req(req), .typeVal(typeVal),
        .show(ackZero | ackOne | slaveSelect), .takeAck(takeAck), .irqPin(irqPin),
        .busType(busType));
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        chk(8'(expQ.size()), 8'h00, "notes left");
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Each new vector takes the oldest note; a vector with no note is a fault.
    // Sampled on the falling edge, clear of the edge that launches the vector.
    always @(negedge clk_sys)
    begin
        vPrev <= vecOut.valid;
        cycles++;
        if (vecOut.valid === 1'b1 && vPrev !== 1'b1)
        begin
            if (expQ.size() == 0)
                chk(8'hff, 8'h00, "unexpected vector");
            else
                chk(vecOut.vector, expQ.pop_front(), "vector");
        end
        if (cycles > 4000)
        begin
            errors++;
            summarize();
        end
    end
    // ----------------------------------------
    // Driver tasks
    // ----------------------------------------
    task automatic enable();
        intEnableSet <= 1'b1;
        @(posedge clk_sys);
        intEnableSet <= 1'b0;
    endtask
    task automatic raise(input int idx);
        req <= 5'h01 << idx;
        @(posedge clk_sys);
        req <= 5'h00;
    endtask
    // Waits are bounded; the settle time after a take lets a level input drop
    task automatic serve(input logic [7:0] exp, input logic ackExp);
        expQ.push_back(exp);
        repeat (40) if (vecOut.valid !== 1'b1) @(negedge clk_sys);
        chk(vecOut.valid, 1'b1, "valid");
        chk(ackZero | ackOne, ackExp, "ack");
        @(posedge clk_sys);
        takeAck <= 1'b1;
        @(posedge clk_sys);
        takeAck <= 1'b0;
        @(negedge clk_sys);
        chk(intEnable, 1'b0, "enable after take");
        repeat (6) @(posedge clk_sys);
    endtask
    initial
    begin
        cfg.levelTrig <= 5'($random(seed));
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            enable();
            raise(i);
            serve(8'h0c + 8'(i), 1'b0);
        end
        $display("normal inputs done");
        cfg.mask <= 5'h10;
        enable();
        raise(4);
        repeat (12) @(posedge clk_sys);
        cfg.mask <= 5'h00;
        serve(8'h10, 1'b0);
        $display("mask done");
        cfg.mode <= MODE_CASCADE;
        cfg.cascOne <= 1'b1;
        @(negedge clk_sys);
        chk(pinTwoOut, 1'b1, "pin two out");
        chk(pinThreeOut, 1'b1, "pin three out");
        @(posedge clk_sys);
        for (int i = 0; i < 2; i++)
        begin
            typeVal <= 8'($random(seed));
            enable();
            raise(i);
            serve(typeVal, 1'b1);
        end
        $display("cascade done");
        cfg.mode <= MODE_SLAVE;
        cfg.cascOne <= 1'b0;
        slaveReqIn <= 1'b1;
        @(negedge clk_sys);
        chk(slaveReqOut, 1'b1, "slave request");
        chk(pinThreeOut, 1'b1, "pin three out");
        @(posedge clk_sys);
        raise(0);
        // Let input zero lead select by a cycle at the pins
        @(posedge clk_sys);
        typeVal <= 8'($random(seed));
        slaveSelect <= 1'b1;
        repeat (6) @(posedge clk_sys);
        slaveSelect <= 1'b0;
        enable();
        serve(typeVal, 1'b0);
        $display("slave done");
        summarize();
    end
endmodule

// >>> verilog/ext_irq_pins.sv
// External maskable interrupt pin logic: sync, recognition, cascade and slave
`timescale 1ns/10ps
`include "ext_irq_map.svh"
module ext_irq_pins
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire ext_irq_pkg::irqCfg_t cfg,
    input  wire logic                 intEnableSet,
    input  wire logic [4:0]           irqPin,
    input  wire logic                 slaveSelect,
    input  wire logic [7:0]           busType,
    input  wire logic                 slaveReqIn,
    input  wire logic                 takeAck,
    output ext_irq_pkg::irqVec_t      vecOut,
    output logic                      intEnable,
    output logic                      cascade_ack_zero,
    output logic                      cascade_ack_one,
    output logic                      slaveReqOut,
    output logic                      pinTwoIsOutput,
    output logic                      pinThreeIsOutput
);
    import ext_irq_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers and recognition
    // ------------------------------------------------------------
    logic [4:0] sync1_r, sync2_r, prev_r, pend_r, pend_nxt;
    logic       sel1_r, sel2_r;
    logic       selPrev_r;
    logic [4:0] active;
    logic       cascZero, slaveMode;
    logic [4:0] ready;
    logic [2:0] grant;
    logic [2:0] srcIdx_r;
    logic       any;

    assign cascZero  = (cfg.mode == MODE_CASCADE);
    assign slaveMode = (cfg.mode == MODE_SLAVE);

    // Pins reused as outputs never raise requests
    always_comb
    begin
        active = 5'h1f;
        if (cascZero || slaveMode)
            active[2] = 1'b0;
        if (cfg.cascOne || slaveMode)
            active[3] = 1'b0;
    end

    // Edge inputs latch until acknowledged; level inputs follow the pin
    always_comb
    begin
        for (int i = 0; i < `IRQ_COUNT; i++)
        begin
            if (!active[i])
                pend_nxt[i] = 1'b0;
            else if (cfg.levelTrig[i])
                pend_nxt[i] = sync2_r[i];
            else if (sync2_r[i] && !prev_r[i])
                pend_nxt[i] = 1'b1;
            // Clear the input the offered vector came from, not the current winner
            else if (takeAck && vecOut.valid && srcIdx_r == 3'(i))
                pend_nxt[i] = 1'b0;
            else
                pend_nxt[i] = pend_r[i];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            prev_r  <= 5'h00;
            pend_r  <= 5'h00;
            sel1_r  <= 1'b0;
            sel2_r  <= 1'b0;
            selPrev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= irqPin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            pend_r  <= pend_nxt;
            sel1_r  <= slaveSelect;
            sel2_r  <= sel1_r;
            selPrev_r <= sel2_r;
        end
    end

    // ------------------------------------------------------------
    // Priority, vector and acknowledge
    // ------------------------------------------------------------
    logic [2:0] srcIdx_nxt;
    irqVec_t    vec_nxt;
    logic       ie_nxt, ack0_nxt, ack1_nxt;
    logic [7:0] slaveType_r, slaveType_nxt;

    assign ready = pend_r & ~cfg.mask;

    // Lowest numbered input wins
    always_comb
    begin
        grant = 3'h0;
        any   = 1'b0;
        for (int i = `IRQ_COUNT - 1; i >= 0; i--)
        begin
            if (ready[i])
            begin
                grant = 3'(i);
                any   = 1'b1;
            end
        end
    end

    always_comb
    begin
        vec_nxt       = vecOut;
        ie_nxt        = intEnable | intEnableSet;
        ack0_nxt      = 1'b0;
        ack1_nxt      = 1'b0;
        slaveType_nxt = slaveType_r;
        srcIdx_nxt    = srcIdx_r;
        // Take the type on the rising synced select only: the synced copy lags
        // the pin by two cycles, so its tail could catch a bus already released
        if (slaveMode && sel2_r && !selPrev_r)
            slaveType_nxt = busType;
        if (vecOut.valid && takeAck)
        begin
            vec_nxt.valid = 1'b0;
            ie_nxt        = intEnableSet;
        end
        else if (!vecOut.valid && intEnable && any)
        begin
            srcIdx_nxt = grant;
            if (slaveMode && grant == 3'h0)
            begin
                vec_nxt.valid  = 1'b1;
                vec_nxt.vector = slaveType_r;
            end
            else if ((cascZero && grant == 3'h0) || (cfg.cascOne && grant == 3'h1))
            begin
                // Wait until the acknowledge stands, so the peer has the type on the bus
                if ((grant == 3'h0 && cascade_ack_zero) || (grant == 3'h1 && cascade_ack_one))
                begin
                    vec_nxt.valid  = 1'b1;
                    vec_nxt.vector = busType;
                end
            end
            else
            begin
                vec_nxt.valid  = 1'b1;
                vec_nxt.vector = `IRQ_VEC_BASE + 8'(grant);
            end
        end
        // Ask for a type while the paired cascaded request waits
        if (cascZero && intEnable && ready[0])
            ack0_nxt = 1'b1;
        if (cfg.cascOne && intEnable && ready[1] && !ready[0])
            ack1_nxt = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            vecOut           <= '0;
            intEnable        <= 1'b0;
            cascade_ack_zero <= 1'b0;
            cascade_ack_one  <= 1'b0;
            slaveType_r      <= 8'h00;
            srcIdx_r         <= 3'h0;
        end
        else
        begin
            vecOut           <= vec_nxt;
            intEnable        <= ie_nxt;
            cascade_ack_zero <= ack0_nxt;
            cascade_ack_one  <= ack1_nxt;
            slaveType_r      <= slaveType_nxt;
            srcIdx_r         <= srcIdx_nxt;
        end
    end

    assign slaveReqOut      = slaveMode & slaveReqIn;
    assign pinTwoIsOutput   = cascZero;
    assign pinThreeIsOutput = cfg.cascOne | slaveMode;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence acceptSeq;
        vecOut.valid && takeAck;
    endsequence

    ie_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        acceptSeq and !intEnableSet |=> !intEnable)
        else $error("enable flag not cleared on accept");
    pin_sync_a: assert property (@(posedge clk_sys) disable iff (reset)
        cfg.levelTrig[4] && !cfg.mask[4] && $stable(cfg) && irqPin[4] ##1 irqPin[4]
        |=> ##1 pend_r[4])
        else $error("level request not seen after sync");
    casc_two_a: assert property (@(posedge clk_sys) disable iff (reset)
        cascZero |-> !pend_r[2] || $past(!cascZero))
        else $error("cascaded pin two raised a request");
    casc_three_a: assert property (@(posedge clk_sys) disable iff (reset)
        cfg.cascOne && $past(cfg.cascOne) |-> !pend_r[3])
        else $error("cascaded pin three raised a request");
    ack_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        cascZero && intEnable && ready[0] |=> cascade_ack_zero)
        else $error("acknowledge zero missing");
    slave_req_a: assert property (@(posedge clk_sys) disable iff (reset)
        slaveMode |-> slaveReqOut == slaveReqIn)
        else $error("slave request not driven");
    slave_type_a: assert property (@(posedge clk_sys) disable iff (reset)
        slaveMode && sel2_r && !selPrev_r |=> slaveType_r == $past(busType))
        else $error("slave type not captured");
    // A cascaded vector must not be formed before its acknowledge is out
    casc_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
        !vecOut.valid && cascZero && grant == 3'h0 && !cascade_ack_zero |=> !vecOut.valid)
        else $error("cascaded vector formed before acknowledge");
    casc_type_a: assert property (@(posedge clk_sys) disable iff (reset)
        !vecOut.valid && intEnable && ready[0] && cascZero && cascade_ack_zero
        |=> vecOut.valid && vecOut.vector == $past(busType))
        else $error("cascaded type not taken from bus");
    ack_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
        !intEnable |=> !cascade_ack_zero && !cascade_ack_one)
        else $error("acknowledge raised while disabled");
    vec_plain_a: assert property (@(posedge clk_sys) disable iff (reset)
        !vecOut.valid && intEnable && any && cfg.mode == MODE_NORMAL && !cfg.cascOne
        |=> vecOut.valid && vecOut.vector == `IRQ_VEC_BASE + 8'($past(grant)))
        else $error("wrong vector");
    mask_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        !vecOut.valid && (ready == 5'h00) |=> !vecOut.valid)
        else $error("masked request taken");
endmodule
